// [rtl/calib_coeff_decoder.sv]
// unpacks stored calibration bits into parallel correction coefficients
`timescale 1ns/1ps
`include "calib_coeff_consts.svh"

module calib_coeff_decoder
  import calib_coeff_pkg::*;
#(
  parameter int RAW_W = 14
) (
  // clock, reset, enable
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  input  wire logic                 clk_en,
  // stored image load
  input  wire logic                 image_load,
  input  wire logic [99:15]         image_bits,
  // raw readings
  input  wire logic [RAW_W-1:0]     raw_bridge_reading,
  input  wire logic [RAW_W-1:0]     raw_temp_reading,
  // bridge gain and offset
  output logic      [14:0]          bridge_gain_coeff,
  output logic      [16:0]          bridge_gain_eff,
  output logic signed [13:0]        bridge_offset_coeff,
  // temperature correction
  output logic      [7:0]           temp_gain_coeff,
  output logic signed [7:0]         temp_offset_coeff,
  output logic      [7:0]           temp_reference_raw,
  // first-order drift
  output logic signed [9:0]         bridge_gain_drift,
  output logic signed [12:0]        bridge_offset_drift,
  output logic      [3:0]           tempco_options,
  output logic                      bridge_polarity_flip,
  // second-order term
  output logic signed [11:0]        second_order_coeff,
  output second_order_target_t      second_order_target,
  output logic                      second_order_target_bad,
  // preamp
  output logic      [5:0]           preamp_gain,
  output logic                      preamp_gain_untested,
  // raw readings as values
  output logic      [RAW_W-1:0]     bridge_raw_value,
  output logic      [RAW_W+1:0]     temp_raw_value,
  // image state
  output logic                      image_valid
);

  // image, validity and raw sample registers
  logic [99:15]         image_reg;
  logic [99:15]         image_next;
  logic                 valid_reg;
  logic                 valid_next;
  logic [RAW_W-1:0]     bridge_raw_reg;
  logic [RAW_W-1:0]     bridge_raw_next;
  logic [RAW_W+1:0]     temp_raw_reg;
  logic [RAW_W+1:0]     temp_raw_next;

  // decoded from the next image, so outputs leave flops with one cycle latency
  logic [14:0]          gain_coeff_reg;
  logic [14:0]          gain_coeff_next;
  logic [16:0]          gain_eff_reg;
  logic [16:0]          gain_eff_next;
  logic signed [13:0]   offset_coeff_reg;
  logic signed [13:0]   offset_coeff_next;
  logic [7:0]           temp_gain_reg;
  logic [7:0]           temp_gain_next;
  logic signed [7:0]    temp_offset_reg;
  logic signed [7:0]    temp_offset_next;
  logic [7:0]           temp_ref_reg;
  logic [7:0]           temp_ref_next;
  logic signed [9:0]    gain_drift_reg;
  logic signed [9:0]    gain_drift_next;
  logic signed [12:0]   offset_drift_reg;
  logic signed [12:0]   offset_drift_next;
  logic [3:0]           options_reg;
  logic [3:0]           options_next;
  logic                 flip_reg;
  logic                 flip_next;
  logic signed [11:0]   sot_coeff_reg;
  logic signed [11:0]   sot_coeff_next;
  second_order_target_t target_reg;
  second_order_target_t target_next;
  logic                 target_bad_reg;
  logic                 target_bad_next;
  logic [5:0]           preamp_reg;
  logic [5:0]           preamp_next;
  logic                 untested_reg;
  logic                 untested_next;

  assign image_next = image_load ? image_bits : image_reg;
  assign valid_next = valid_reg | image_load;
  assign bridge_raw_next = raw_bridge_reading;
  // two lsbs carry no weight, so range stays 0..16380
  assign temp_raw_next = {2'b00, raw_temp_reading[RAW_W-1:2], 2'b00};

  // field slices
  wire [14:0] gain_b_w   = image_next[`GAIN_B_HI:`GAIN_B_LO];
  wire [13:0] offset_b_w = image_next[`OFFSET_B_HI:`OFFSET_B_LO];
  wire [7:0]  gain_t_w   = image_next[`GAIN_T_HI:`GAIN_T_LO];
  wire [7:0]  offset_t_w = image_next[`OFFSET_T_HI:`OFFSET_T_LO];
  wire [7:0]  tref_w     = image_next[`TREF_HI:`TREF_LO];
  wire [7:0]  tcg_w      = image_next[`TCG_HI:`TCG_LO];
  wire [7:0]  tco_w      = image_next[`TCO_HI:`TCO_LO];
  wire [3:0]  tcopt_w    = image_next[`TCOPT_HI:`TCOPT_LO];
  wire [7:0]  sot_w      = image_next[`SOT_HI:`SOT_LO];
  wire [1:0]  pamp_w     = image_next[`PAMP_HI:`PAMP_LO];
  wire [1:0]  sotcfg_w   = image_next[`SOTCFG_HI:`SOTCFG_LO];

  assign gain_coeff_next = gain_b_w;
  // scale flag x8; lsb weighs 2^-11
  wire [16:0] gain_mag_w = {3'b000, gain_b_w[13:0]};
  assign gain_eff_next = gain_b_w[14] ? (gain_mag_w << `X8_SHIFT) : gain_mag_w;

  assign offset_coeff_next = $signed(offset_b_w);
  assign temp_gain_next = gain_t_w;
  assign temp_offset_next = $signed(offset_t_w);
  assign temp_ref_next = tref_w;

  assign options_next = tcopt_w;
  assign flip_next = tcopt_w[`TCOPT_POL_BIT];

  // gain drift magnitude; sign from option bit 2
  wire signed [9:0] tcg_pos_w = $signed({2'b00, tcg_w});
  assign gain_drift_next = tcopt_w[`TCOPT_TCG_NEG_BIT] ? -tcg_pos_w : tcg_pos_w;

  wire        tco_x8_w = tcopt_w[`TCOPT_TCO_X8_BIT];
  wire [11:0] tco_mag_w = tco_x8_w ? ({4'h0, tco_w} << `X8_SHIFT) : {4'h0, tco_w};
  wire signed [12:0] tco_pos_w = $signed({1'b0, tco_mag_w});
  assign offset_drift_next = tcopt_w[`TCOPT_TCO_NEG_BIT] ? -tco_pos_w : tco_pos_w;

  assign target_next = second_order_target_t'(sotcfg_w);
  assign target_bad_next = (sotcfg_w == 2'b11);

  // sign-magnitude term; x8 when aimed at offset drift with the offset drift x8 option set
  wire        sot_x8_w = tco_x8_w && (sotcfg_w == 2'b10);
  wire [10:0] sot_mag_w = sot_x8_w ? ({4'h0, sot_w[6:0]} << `X8_SHIFT) : {4'h0, sot_w[6:0]};
  wire signed [11:0] sot_pos_w = $signed({1'b0, sot_mag_w});
  assign sot_coeff_next = sot_w[7] ? -sot_pos_w : sot_pos_w;

  assign preamp_next = (pamp_w == 2'b00) ? `PAMP_GAIN_6  :
                       (pamp_w == 2'b01) ? `PAMP_GAIN_24 :
                       (pamp_w == 2'b10) ? `PAMP_GAIN_12 : `PAMP_GAIN_48;
  // only code 01 (gain 24) is factory-tested, other codes are flagged
  assign untested_next = (pamp_w != 2'b01);

  // reset acts whether or not the clock is enabled
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      image_reg <= `IMG_RESET;
      valid_reg <= 1'b0;
    end else if (clk_en) begin
      image_reg <= image_next;
      valid_reg <= valid_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bridge_raw_reg <= '0;
    end else if (clk_en) begin
      bridge_raw_reg <= bridge_raw_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      temp_raw_reg <= '0;
    end else if (clk_en) begin
      temp_raw_reg <= temp_raw_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gain_coeff_reg <= '0;
    end else if (clk_en) begin
      gain_coeff_reg <= gain_coeff_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gain_eff_reg <= '0;
    end else if (clk_en) begin
      gain_eff_reg <= gain_eff_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      offset_coeff_reg <= '0;
    end else if (clk_en) begin
      offset_coeff_reg <= offset_coeff_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      temp_gain_reg <= '0;
    end else if (clk_en) begin
      temp_gain_reg <= temp_gain_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      temp_offset_reg <= '0;
    end else if (clk_en) begin
      temp_offset_reg <= temp_offset_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      temp_ref_reg <= '0;
    end else if (clk_en) begin
      temp_ref_reg <= temp_ref_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gain_drift_reg <= '0;
    end else if (clk_en) begin
      gain_drift_reg <= gain_drift_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      offset_drift_reg <= '0;
    end else if (clk_en) begin
      offset_drift_reg <= offset_drift_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      options_reg <= '0;
    end else if (clk_en) begin
      options_reg <= options_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flip_reg <= 1'b0;
    end else if (clk_en) begin
      flip_reg <= flip_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sot_coeff_reg <= '0;
    end else if (clk_en) begin
      sot_coeff_reg <= sot_coeff_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      target_reg <= sot_on_bridge;
    end else if (clk_en) begin
      target_reg <= target_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      target_bad_reg <= 1'b0;
    end else if (clk_en) begin
      target_bad_reg <= target_bad_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      preamp_reg <= `PAMP_GAIN_6;
    end else if (clk_en) begin
      preamp_reg <= preamp_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      untested_reg <= 1'b1;
    end else if (clk_en) begin
      untested_reg <= untested_next;
    end
  end

  // output ports
  assign bridge_gain_coeff       = gain_coeff_reg;
  assign bridge_gain_eff         = gain_eff_reg;
  assign bridge_offset_coeff     = offset_coeff_reg;
  assign temp_gain_coeff         = temp_gain_reg;
  assign temp_offset_coeff       = temp_offset_reg;
  assign temp_reference_raw      = temp_ref_reg;
  assign bridge_gain_drift       = gain_drift_reg;
  assign bridge_offset_drift     = offset_drift_reg;
  assign tempco_options          = options_reg;
  assign bridge_polarity_flip    = flip_reg;
  assign second_order_coeff      = sot_coeff_reg;
  assign second_order_target     = target_reg;
  assign second_order_target_bad = target_bad_reg;
  assign preamp_gain             = preamp_reg;
  assign preamp_gain_untested    = untested_reg;
  assign bridge_raw_value        = bridge_raw_reg;
  assign temp_raw_value          = temp_raw_reg;
  assign image_valid             = valid_reg;

endmodule

// [rtl/calib_coeff_consts.svh]
// field positions and reset values of the calibration coefficient image
`ifndef CALIB_COEFF_CONSTS_SVH
`define CALIB_COEFF_CONSTS_SVH
`define IMG_LO            15
`define IMG_HI            99
`define GAIN_B_HI         29
`define GAIN_B_LO         15
`define OFFSET_B_HI       43
`define OFFSET_B_LO       30
`define GAIN_T_HI         51
`define GAIN_T_LO         44
`define OFFSET_T_HI       59
`define OFFSET_T_LO       52
`define TREF_HI           67
`define TREF_LO           60
`define TCG_HI            75
`define TCG_LO            68
`define TCO_HI            83
`define TCO_LO            76
`define TCOPT_HI          87
`define TCOPT_LO          84
`define SOT_HI            95
`define SOT_LO            88
`define PAMP_HI           97
`define PAMP_LO           96
`define SOTCFG_HI         99
`define SOTCFG_LO         98
`define TCOPT_POL_BIT     3
`define TCOPT_TCG_NEG_BIT 2
`define TCOPT_TCO_X8_BIT  1
`define TCOPT_TCO_NEG_BIT 0
`define X8_SHIFT          3
`define PAMP_GAIN_6       6'h06
`define PAMP_GAIN_24      6'h18
`define PAMP_GAIN_12      6'h0C
`define PAMP_GAIN_48      6'h30
`define RAW_TEMP_STEP     3'h4
`define IMG_RESET         85'h0
`endif

// [rtl/calib_coeff_pkg.sv]
// types shared by the calibration coefficient decoder
package calib_coeff_pkg;
  typedef enum logic [1:0] {
    sot_on_bridge,
    sot_on_gain_drift,
    sot_on_offset_drift,
    sot_prohibited
  } second_order_target_t;
endpackage

// [tb/calib_coeff_decoder_assertions.sv]
// port-level checker for the coefficient decoder
`timescale 1ns/1ps
module calib_coeff_checker
  import calib_coeff_pkg::*;
#(parameter int RAW_W = 14) (
  input logic ref_clk, srst, clk_en, image_load, bridge_polarity_flip, second_order_target_bad,
  input logic [99:15] image_bits,
  input logic [RAW_W-1:0] raw_temp_reading,
  input logic [RAW_W+1:0] temp_raw_value,
  input logic [14:0] bridge_gain_coeff,
  input logic [16:0] bridge_gain_eff,
  input logic signed [13:0] bridge_offset_coeff,
  input logic signed [9:0] bridge_gain_drift,
  input logic [3:0] tempco_options,
  input logic [5:0] preamp_gain,
  input second_order_target_t second_order_target
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire ld = clk_en && image_load;
  wire [9:0] tcg = {2'h0, image_bits[75:68]};
  a_field_slice: assert property (
    ld |=> {bridge_offset_coeff, bridge_gain_coeff} == $past(image_bits[43:15])) else $error("field slice");
  a_gain_scale: assert property (
    bridge_gain_eff == (bridge_gain_coeff[14] ? {bridge_gain_coeff[13:0], 3'h0} : {3'h0, bridge_gain_coeff[13:0]}))
    else $error("gain scale");
  a_gain_drift: assert property (
    ld |=> bridge_gain_drift == ($past(image_bits[86]) ? -$past(tcg) : $past(tcg))) else $error("gain drift");
  a_opt_polarity: assert property (
    ld |=> tempco_options == $past(image_bits[87:84]) && bridge_polarity_flip == tempco_options[3])
    else $error("options");
  a_target_code: assert property (
    ld |=> second_order_target == $past(image_bits[99:98]) && second_order_target_bad == &second_order_target)
    else $error("target code");
  a_preamp_map: assert property (
    ld |=> preamp_gain == 6'h06 << $past({image_bits[96], image_bits[97]})) else $error("preamp gain");
  a_temp_raw: assert property (
    clk_en |=> temp_raw_value == {2'h0, $past(raw_temp_reading[RAW_W-1:2]), 2'h0}) else $error("raw temperature");
  a_hold_stable: assert property (
    !ld |=> $stable(bridge_gain_coeff) && $stable(bridge_offset_coeff)) else $error("hold");
  c_bad_code: cover property (ld && &image_bits[99:98]);
  c_x8_sot: cover property (ld && image_bits[85] && image_bits[99:98] == 2'h2);
  c_frozen: cover property (image_load && !clk_en);
endmodule

bind calib_coeff_decoder calib_coeff_checker #(.RAW_W(RAW_W)) calib_coeff_checker_inst (.*);

// [tb/calib_host_model.sv]
// calibration host that writes coefficient images
`timescale 1ns/1ps
module calib_host_model (
  input  logic         ref_clk,
  output logic         image_load,
  output logic [99:15] image_bits
);
  initial begin
    image_load = 1'b0;
    image_bits = '0;
  end
  task automatic load(input logic [99:15] img, input bit lawful);
    if (lawful) begin
      if (&img[99:98]) img[99:98] = 2'h0;
      if (img[99:98] == 2'h2) img[29] = 1'b0;
      if (img[99:98] == 2'h0 && img[95] && img[94:88] > 7'h40) img[94:88] = 7'h40;
    end
    @(posedge ref_clk);
    #1 image_bits = img;
    image_load = 1'b1;
    @(posedge ref_clk);
    #1 image_load = 1'b0;
    // released bus shows the inverse so stale data cannot match
    image_bits = ~img;
  endtask
endmodule

// [tb/test_calib_coeff_decoder.sv]
// self-checking bench for the coefficient decoder
`timescale 1ns/1ps
module test_calib_coeff_decoder;
  import calib_coeff_pkg::*;
  logic ref_clk, srst, clk_en, image_load, bridge_polarity_flip, second_order_target_bad, preamp_gain_untested;
  logic image_valid;
  logic [99:15] image_bits, img;
  logic [13:0] raw_bridge_reading, raw_temp_reading, bridge_raw_value;
  logic [14:0] bridge_gain_coeff;
  logic [16:0] bridge_gain_eff;
  logic signed [13:0] bridge_offset_coeff;
  logic [7:0] temp_gain_coeff, temp_reference_raw;
  logic signed [7:0] temp_offset_coeff;
  logic signed [9:0] bridge_gain_drift;
  logic signed [12:0] bridge_offset_drift;
  logic [3:0] tempco_options;
  logic signed [11:0] second_order_coeff;
  second_order_target_t second_order_target;
  logic [5:0] preamp_gain;
  logic [15:0] temp_raw_value;
  int err_count, n_tests;
  calib_coeff_decoder calib_coeff_decoder_inst (.*);
  calib_host_model calib_host_model_inst (.*);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_fields;
    for (int s = 0; s < 2; s++) begin
      img = '0;
      img[67:15] = {24'h5A2980, 14'h3FFC, s[0], 14'h2A31};
      calib_host_model_inst.load(img, 1);
      chk("gain_eff", bridge_gain_eff, s ? 32'h15188 : 32'h2A31);
      chk("offset", bridge_offset_coeff, -4);
      chk("t_fields", {temp_reference_raw, temp_gain_coeff}, 16'h5A80);
      chk("t_offset", temp_offset_coeff, 41);
    end
    $display("fields done");
  endtask
  task automatic t_drift;
    for (int o = 0; o < 16; o++) begin
      img = '0;
      img[99:68] = {4'h9, 8'h85, o[3:0], 8'h9C, 8'hA5};
      calib_host_model_inst.load(img, 1);
      chk("g_drift", bridge_gain_drift, o[2] ? -165 : 165);
      chk("o_drift", bridge_offset_drift, (o[0] ? -156 : 156) * (o[1] ? 8 : 1));
      chk("sot", second_order_coeff, o[1] ? -40 : -5);
      chk("flip", bridge_polarity_flip, o[3]);
    end
    $display("drift done");
  endtask
  task automatic t_codes;
    for (int c = 0; c < 4; c++) begin
      img = '0;
      img[99:84] = {c[1:0], c[1:0], 8'h7F, 4'h2};
      calib_host_model_inst.load(img, 0);
      chk("target", {second_order_target_bad, second_order_target}, {c == 3, c[1:0]});
      chk("preamp", preamp_gain, 6 << (c == 1 ? 2 : c == 2 ? 1 : c));
      chk("untested", preamp_gain_untested, c != 1);
      chk("sot_x8", second_order_coeff, c == 2 ? 1016 : 127);
    end
    $display("codes done");
  endtask
  task automatic t_hold;
    img = '0;
    img[29:15] = 15'h1234;
    calib_host_model_inst.load(img, 1);
    clk_en = 1'b0;
    calib_host_model_inst.load(~img, 1);
    chk("hold", bridge_gain_coeff, 15'h1234);
    raw_bridge_reading = 14'h3FFF;
    raw_temp_reading = 14'h3FFF;
    clk_en = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("raw_b", bridge_raw_value, 14'h3FFF);
    chk("raw_t", temp_raw_value, 16'h3FFC);
    chk("valid", image_valid, 1);
    $display("hold done");
  endtask
  initial begin
    err_count = 0;
    n_tests = 0;
    srst = 1'b1;
    clk_en = 1'b1;
    raw_bridge_reading = 14'h0;
    raw_temp_reading = 14'h0123;
    repeat (12) @(posedge ref_clk);
    #1 srst = 1'b0;
    chk("reset", {image_valid, preamp_gain_untested, preamp_gain}, 8'h46);
    t_fields;
    t_drift;
    t_codes;
    t_hold;
    end_of_test;
  end
  // about 60 cycles expected; allow well over ten times that
  initial begin
    #20000;
    err_count++;
    end_of_test;
  end
endmodule
